// *** bench/abts_chk.sv ***
/*
  Concurrent checks on the datapath's bus answer, prescaler pulse, skip flag and port latch.
  Assumes one clock, synchronous reset and a classic single-cycle wishbone master.
*/
`timescale 1ns/1ps
module abts_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] port_latch_o,
  input wire logic presc_clr_o,
  input wire logic skip_pending_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic exec;
  // instruction executes in the ack cycle of an instruction write
  assign exec = wb_ack_o && wb_we_i && (wb_adr_i == 8'h00);

  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_clr_one; presc_clr_o |=> !presc_clr_o; endproperty
  a_clr_one: assert property (p_clr_one) else $error("clear too long");
  property p_clr_src; presc_clr_o |-> $past(exec); endproperty
  a_clr_src: assert property (p_clr_src) else $error("clear without op");
  property p_skip; $changed(skip_pending_o) |-> $past(exec); endproperty
  a_skip: assert property (p_skip) else $error("skip moved alone");
  property p_latch; $changed(port_latch_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i); endproperty
  a_latch: assert property (p_latch) else $error("latch moved alone");
  property p_nop; skip_pending_o && exec |=> !skip_pending_o; endproperty
  a_nop: assert property (p_nop) else $error("skip not consumed");
  property p_nop_clr; skip_pending_o && exec |=> !presc_clr_o; endproperty
  a_nop_clr: assert property (p_nop_clr) else $error("skipped op acted");

  c_clr: cover property (presc_clr_o);
  c_skip: cover property ($rose(skip_pending_o));
  c_nop: cover property (skip_pending_o && exec);
endmodule

bind abts_core abts_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .port_latch_o(port_latch_o),
  .presc_clr_o(presc_clr_o), .skip_pending_o(skip_pending_o));

// *** bench/abts_pin_model.sv ***
/*
  Pin-side device model: an outside driver holding the port pins.
  Assumes the bench picks the level; pins are strongly driven, never released.
*/
`timescale 1ns/1ps
module abts_pin_model (
  input wire logic [7:0] lvl_i,
  output logic [7:0] pins_o
);
  // outside driver beats the latch, so reads see this level
  assign pins_o = lvl_i;
endmodule

// *** bench/testbench.sv ***
/*
  Self-checking bench: instruction and register accesses over wishbone.
  Assumes the hand-over register map and a 100 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack;
  logic pclr;
  logic skip;
  logic [7:0] latch;
  logic [7:0] lvl = 8'ha5;
  logic [7:0] pins;
  int bad_count = 0;
  int total_checks = 0;
  int pcnt = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (pclr === 1'b1) pcnt <= pcnt + 1;

  abts_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(dat_o), .port_pins_i(pins),
    .port_latch_o(latch), .presc_clr_o(pclr), .skip_pending_o(skip));
  abts_pin_model pm (.lvl_i(lvl), .pins_o(pins));

  task automatic results;
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // entered just after an edge; ack is sampled at edges only
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1)
    begin
      chk("bus_timeout", 1, 0);
      results;
    end
    else
    begin
      rdat = dat_o;
      cyc <= 0;
      stb <= 0;
      we <= 0;
      @(posedge clk_i);
    end
  endtask
  task automatic ex(input logic [11:0] op);
    bus(1, 8'h00, {20'h0, op});
  endtask
  task automatic rd(input logic [7:0] a, input string n, input logic [31:0] e);
    bus(0, a, 0);
    chk(n, e, rdat);
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(8'h08, "st_rst", 0);
    rd(8'h40, "unmapped", 0);
    bus(1, 8'h04, 8'h0f);
    bus(1, 8'h88, 8'hf8);
    ex(12'h1c2);
    rd(8'h04, "add_w", 8'h07);
    rd(8'h08, "add_st", 8'h03);
    rd(8'h88, "add_f_kept", 8'hf8);
    ex(12'he00);
    rd(8'h04, "andl_w", 0);
    rd(8'h08, "andl_st", 8'h07);
    bus(1, 8'h04, 8'h07);
    ex(12'h1e2);
    rd(8'h88, "add_f", 8'hff);
    rd(8'h08, "add_st2", 0);
    bus(1, 8'h04, 8'h3c);
    bus(1, 8'h08, 8'h07);
    ex(12'h162);
    rd(8'h88, "andf_f", 8'h3c);
    rd(8'h04, "andf_w", 8'h3c);
    rd(8'h08, "andf_st", 8'h03);
    ex(12'h502);
    ex(12'h4a2);
    rd(8'h88, "bits_f", 8'h1d);
    rd(8'h08, "bits_st", 8'h03);
    ex(12'h622);
    chk("skip_low", 1, skip);
    ex(12'he00);
    chk("skip_done", 0, skip);
    rd(8'h04, "nop_w", 8'h3c);
    ex(12'h702);
    chk("skip_high", 1, skip);
    ex(12'h622);
    chk("skip_test_nop", 0, skip);
    ex(12'h722);
    chk("noskip_high", 0, skip);
    ex(12'h602);
    chk("noskip_low", 0, skip);
    rd(8'h08, "test_st", 8'h03);
    bus(1, 8'h0c, 1);
    bus(1, 8'h84, 8'h55);
    ex(12'h501);
    ex(12'h1c1);
    ex(12'h161);
    bus(1, 8'h0c, 0);
    ex(12'h521);
    chk("clr_count", 2, pcnt);
    bus(1, 8'h98, 8'h00);
    ex(12'h526);
    chk("latch", 8'ha7, latch);
    rd(8'h98, "pins", 8'ha5);
    // unsupported opcode: sticky flag, flags untouched, write 1 clears
    ex(12'h3ff);
    rd(8'h08, "bad_st", 8'h12);
    bus(1, 8'h08, 8'h12);
    rd(8'h08, "bad_clr", 8'h02);
    // test on the port reads pins (bit1 low), not the latch (bit1 high)
    ex(12'h626);
    chk("skip_pins", 1, skip);
    rd(8'h08, "skip_st", 8'h0a);
    // mid-run reset must clear skip, latch and work register
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk("rst_skip", 0, skip);
    chk("rst_latch", 0, latch);
    chk("rst_pclr", 0, pclr);
    rd(8'h04, "rst_w", 0);
    rd(8'h08, "rst_st", 0);
    results;
  end
endmodule

// *** rtl/abts_alu.sv ***
/*
  Combinational ALU: add, and, bit set/clear, bit extract.
  Assumes the core commits results and flags only for ops that own them.
*/
`timescale 1ns/1ps
module abts_alu
  import abts_pkg::*;
(
  abts_alu_if.alu a
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] mask;

  always_comb
  begin
    sum = {1'b0, a.w_val} + {1'b0, a.f_val};
    nib = {1'b0, a.w_val[3:0]} + {1'b0, a.f_val[3:0]};
    mask = 8'h01 << a.bit_sel;
    a.res = a.f_val;
    a.c_out = a.c_in;
    a.dc_out = a.dc_in;
    a.z_out = a.z_in;
    a.bit_out = a.f_val[a.bit_sel];
    case (a.op)
      add_work_to_file:
      begin
        a.res = sum[7:0];
        a.c_out = sum[8];
        a.dc_out = nib[4];
        a.z_out = (sum[7:0] == 8'h00);
      end
      and_work_file_op:
      begin
        a.res = a.w_val & a.f_val;
        a.z_out = ((a.w_val & a.f_val) == 8'h00);
      end
      and_literal_op:
      begin
        a.res = a.w_val & a.lit;
        a.z_out = ((a.w_val & a.lit) == 8'h00);
      end
      bit_clear_op: a.res = a.f_val & ~mask;
      bit_set_op: a.res = a.f_val | mask;
      default: a.res = a.f_val;
    endcase
  end
endmodule

// *** rtl/abts_alu_if.sv ***
/*
  Operand and result bundle between the core and its ALU.
  Assumes the core drives operands and the ALU answers combinationally.
*/
`timescale 1ns/1ps
interface abts_alu_if;
  import abts_pkg::*;
  abts_op_t op;
  logic [7:0] w_val;
  logic [7:0] f_val;
  logic [7:0] lit;
  logic [2:0] bit_sel;
  logic c_in;
  logic dc_in;
  logic z_in;
  logic [7:0] res;
  logic c_out;
  logic dc_out;
  logic z_out;
  logic bit_out;

  modport core (
    output op, w_val, f_val, lit, bit_sel, c_in, dc_in, z_in,
    input res, c_out, dc_out, z_out, bit_out
  );
  modport alu (
    input op, w_val, f_val, lit, bit_sel, c_in, dc_in, z_in,
    output res, c_out, dc_out, z_out, bit_out
  );
endinterface

// *** rtl/abts_core.sv ***
/*
  Execution datapath for add, and, bit set/clear and bit-test-skip ops,
  with working register, flags, 32 file registers and a port latch.
  Assumes a classic Wishbone master; pins are asynchronous to clk_i.
*/
`timescale 1ns/1ps
`include "abts_defines.svh"
module abts_core
  import abts_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic [7:0] port_pins_i,
  output logic [7:0] port_latch_o,
  output logic presc_clr_o,
  output logic skip_pending_o
);
  abts_alu_if alu_bus ();

  logic [7:0] pins_s;
  logic [7:0] work_q;
  logic c_q;
  logic dc_q;
  logic z_q;
  logic bad_q;
  logic presc_tmr_q;
  logic [11:0] instr_q;
  logic go_q;
  logic [7:0] file_mem [32];

  logic req;
  logic bus_wr;
  logic win_hit;
  logic [4:0] win_idx;
  logic [31:0] rd_d;
  abts_op_t op;
  logic [4:0] f_addr;
  logic dest_file;
  logic live;
  logic wr_file;
  logic wr_work;
  logic upd_flags;
  logic take_skip;

  abts_sync #(
    .WIDTH(8)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(port_pins_i),
    .q_o(pins_s)
  );

  abts_alu u_alu (
    .a(alu_bus.alu)
  );

  // bus decode
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = req & wb_we_i;
  assign win_hit = wb_adr_i[`ABTS_FILE_WIN_BIT];
  assign win_idx = wb_adr_i[6:2];

  function automatic abts_op_t decode(input logic [11:0] ins);
    abts_op_t r;
    r = unsupported_op;
    if (ins == `ABTS_INS_NOP)
    begin
      r = nop_op;
    end
    else
    begin
      case (ins[11:8])
        `ABTS_OPC_ALU:
        begin
          if (ins[7:6] == `ABTS_SUB_ADD)
          begin
            r = add_work_to_file;
          end
          else if (ins[7:6] == `ABTS_SUB_AND)
          begin
            r = and_work_file_op;
          end
          else
          begin
            r = unsupported_op;
          end
        end
        `ABTS_OPC_BCLR: r = bit_clear_op;
        `ABTS_OPC_BSET: r = bit_set_op;
        `ABTS_OPC_TSTL: r = test_skip_if_low;
        `ABTS_OPC_TSTH: r = test_skip_if_high;
        `ABTS_OPC_ANDL: r = and_literal_op;
        default: r = unsupported_op;
      endcase
    end
    return r;
  endfunction

  // execute decode
  assign op = decode(instr_q);
  assign f_addr = instr_q[`ABTS_F_FILE_HI:`ABTS_F_FILE_LO];
  assign dest_file = instr_q[`ABTS_F_DEST];
  // a pending skip swallows this issue slot as a no-operation
  assign live = go_q & ~skip_pending_o;

  always_comb
  begin
    wr_file = 1'b0;
    wr_work = 1'b0;
    upd_flags = 1'b0;
    take_skip = 1'b0;
    if (live)
    begin
      case (op)
        add_work_to_file, and_work_file_op:
        begin
          wr_file = dest_file;
          wr_work = ~dest_file;
          upd_flags = 1'b1;
        end
        and_literal_op:
        begin
          wr_work = 1'b1;
          upd_flags = 1'b1;
        end
        bit_clear_op, bit_set_op: wr_file = 1'b1;
        test_skip_if_low: take_skip = ~alu_bus.bit_out;
        test_skip_if_high: take_skip = alu_bus.bit_out;
        default: take_skip = 1'b0;
      endcase
    end
  end

  // operands to the alu
  always_comb
  begin
    alu_bus.op = op;
    alu_bus.w_val = work_q;
    // read-modify-write of the port sees the pins, not the latch
    alu_bus.f_val = (f_addr == `ABTS_FILE_PORT) ? pins_s : file_mem[f_addr];
    alu_bus.lit = instr_q[7:0];
    alu_bus.bit_sel = instr_q[`ABTS_F_BIT_HI:`ABTS_F_BIT_LO];
    alu_bus.c_in = c_q;
    alu_bus.dc_in = dc_q;
    alu_bus.z_in = z_q;
  end

  // instruction issue from the bus; needs both low byte lanes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      instr_q <= `ABTS_RST_INSTR;
      go_q <= 1'b0;
    end
    else if (bus_wr && !win_hit && wb_adr_i == `ABTS_OFS_INSTR && wb_sel_i[1:0] == 2'b11)
    begin
      instr_q <= wb_dat_i[11:0];
      go_q <= 1'b1;
    end
    else
    begin
      go_q <= 1'b0;
    end
  end

  // skip pending: set by a taken test, consumed by the next issue
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      skip_pending_o <= 1'b0;
    end
    else if (take_skip)
    begin
      skip_pending_o <= 1'b1;
    end
    else if (go_q)
    begin
      skip_pending_o <= 1'b0;
    end
  end

  // working register; execution wins over a bus write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      work_q <= `ABTS_RST_WORK;
    end
    else if (wr_work)
    begin
      work_q <= alu_bus.res;
    end
    else if (bus_wr && !win_hit && wb_adr_i == `ABTS_OFS_WORK && wb_sel_i[0])
    begin
      work_q <= wb_dat_i[7:0];
    end
  end

  // flags; bit and skip ops never touch them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      c_q <= 1'b0;
      dc_q <= 1'b0;
      z_q <= 1'b0;
    end
    else if (upd_flags)
    begin
      c_q <= alu_bus.c_out;
      dc_q <= alu_bus.dc_out;
      z_q <= alu_bus.z_out;
    end
    else if (bus_wr && !win_hit && wb_adr_i == `ABTS_OFS_STATUS && wb_sel_i[0])
    begin
      c_q <= wb_dat_i[`ABTS_ST_C];
      dc_q <= wb_dat_i[`ABTS_ST_DC];
      z_q <= wb_dat_i[`ABTS_ST_Z];
    end
  end

  // sticky unsupported-opcode flag; a new event beats a clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bad_q <= 1'b0;
    end
    else if (live && op == unsupported_op)
    begin
      bad_q <= 1'b1;
    end
    else if (bus_wr && !win_hit && wb_adr_i == `ABTS_OFS_STATUS && wb_sel_i[0] && wb_dat_i[`ABTS_ST_BAD])
    begin
      bad_q <= 1'b0;
    end
  end

  // prescaler ownership
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      presc_tmr_q <= 1'b0;
    end
    else if (bus_wr && !win_hit && wb_adr_i == `ABTS_OFS_CTRL && wb_sel_i[0])
    begin
      presc_tmr_q <= wb_dat_i[`ABTS_CT_PRESC_TMR];
    end
  end

  // prescaler clear pulse on a timer write-back
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      presc_clr_o <= 1'b0;
    end
    else
    begin
      presc_clr_o <= wr_file && f_addr == `ABTS_FILE_TIMER && presc_tmr_q;
    end
  end

  // file array, no reset: contents undefined until written
  always_ff @(posedge clk_i)
  begin
    if (wr_file && f_addr != `ABTS_FILE_PORT)
    begin
      file_mem[f_addr] <= alu_bus.res;
    end
    else if (bus_wr && win_hit && win_idx != `ABTS_FILE_PORT && wb_sel_i[0])
    begin
      file_mem[win_idx] <= wb_dat_i[7:0];
    end
  end

  // port output latch lives apart from the array
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_latch_o <= `ABTS_RST_PORT;
    end
    else if (wr_file && f_addr == `ABTS_FILE_PORT)
    begin
      port_latch_o <= alu_bus.res;
    end
    else if (bus_wr && win_hit && win_idx == `ABTS_FILE_PORT && wb_sel_i[0])
    begin
      port_latch_o <= wb_dat_i[7:0];
    end
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (win_hit)
    begin
      rd_d[7:0] = (win_idx == `ABTS_FILE_PORT) ? pins_s : file_mem[win_idx];
    end
    else
    begin
      case (wb_adr_i)
        `ABTS_OFS_INSTR: rd_d[11:0] = instr_q;
        `ABTS_OFS_WORK: rd_d[7:0] = work_q;
        `ABTS_OFS_STATUS:
        begin
          rd_d[`ABTS_ST_C] = c_q;
          rd_d[`ABTS_ST_DC] = dc_q;
          rd_d[`ABTS_ST_Z] = z_q;
          rd_d[`ABTS_ST_SKIP] = skip_pending_o;
          rd_d[`ABTS_ST_BAD] = bad_q;
        end
        `ABTS_OFS_CTRL: rd_d[`ABTS_CT_PRESC_TMR] = presc_tmr_q;
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  // single-cycle ack; drops the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
      begin
        wb_dat_o <= rd_d;
      end
    end
  end
endmodule

// *** rtl/abts_defines.svh ***
/*
  Offsets, field positions, opcode fields and reset values for the
  bit-test/skip ALU datapath. Assumes byte addresses on a 32-bit Wishbone bus.
*/
`ifndef ABTS_DEFINES_SVH
`define ABTS_DEFINES_SVH

// register byte offsets
`define ABTS_OFS_INSTR 8'h00
`define ABTS_OFS_WORK 8'h04
`define ABTS_OFS_STATUS 8'h08
`define ABTS_OFS_CTRL 8'h0c
// file window: bit 7 set, file index in bits 6:2
`define ABTS_FILE_WIN_BIT 7

// status bit positions
`define ABTS_ST_C 0
`define ABTS_ST_DC 1
`define ABTS_ST_Z 2
`define ABTS_ST_SKIP 3
`define ABTS_ST_BAD 4
// control bit positions
`define ABTS_CT_PRESC_TMR 0

// instruction fields
`define ABTS_F_DEST 5
`define ABTS_F_BIT_HI 7
`define ABTS_F_BIT_LO 5
`define ABTS_F_FILE_HI 4
`define ABTS_F_FILE_LO 0

// opcode fields
`define ABTS_INS_NOP 12'h000
`define ABTS_OPC_ALU 4'h1
`define ABTS_SUB_ADD 2'h3
`define ABTS_SUB_AND 2'h1
`define ABTS_OPC_BCLR 4'h4
`define ABTS_OPC_BSET 4'h5
`define ABTS_OPC_TSTL 4'h6
`define ABTS_OPC_TSTH 4'h7
`define ABTS_OPC_ANDL 4'he

// special file addresses
`define ABTS_FILE_TIMER 5'h01
`define ABTS_FILE_PORT 5'h06

// reset values
`define ABTS_RST_WORK 8'h00
`define ABTS_RST_PORT 8'h00
`define ABTS_RST_INSTR 12'h000

`endif

// *** rtl/abts_pkg.sv ***
/*
  Types shared by the datapath, its ALU and their interface.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package abts_pkg;

  typedef enum logic [3:0] {
    nop_op,
    add_work_to_file,
    and_work_file_op,
    and_literal_op,
    bit_clear_op,
    bit_set_op,
    test_skip_if_low,
    test_skip_if_high,
    unsupported_op
  } abts_op_t;

endpackage

// *** rtl/abts_sync.sv ***
/*
  Two-flop synchroniser for a bus of asynchronous levels.
  Assumes the inputs change slowly relative to clk_i; no bus coherence.
*/
`timescale 1ns/1ps
module abts_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule
